/* design/cmc_consts.vh */
// constants for the clock mode configuration block
`ifndef CMC_CONSTS_VH
`define CMC_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CMC_ADDR_W 17
`define CMC_OFS_CTRL 17'h10C80
`define CMC_OFS_MODE 17'h10C88

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CMC_CLOCK_OUTPUT_DISABLE_BIT 27
`define CMC_BAUD_HI 31
`define CMC_BAUD_LO 30
`define CMC_BAUD_RST 2'h1
`define CMC_CLOCK_OUTPUT_DISABLE_RST 1'h0

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define CMC_CPDF_LO 0
`define CMC_CMF_LO 4
`define CMC_BUS_DIVIDE_FACTOR_LO 8
`define CMC_COMMS_DIVIDE_FACTOR_LO 12
`define CMC_SPDF_LO 16
`define CMC_SMF_LO 20
`define CMC_DLL_BIT 25
`define CMC_CORE_DIVIDE_FACTOR_LO 28
`define CMC_MODE_RSV 32'h0D000000

// ----------------------------------------
// synchroniser layout
// ----------------------------------------
`define CMC_SYNC_POR 6
`define CMC_SYNC_RST 8'h40

// ----------------------------------------
// fixed divide values
// ----------------------------------------
`define CMC_SER_DIV 9'h004
`define CMC_BAUD_DIV0 9'h004
`define CMC_BAUD_DIV1 9'h010
`define CMC_BAUD_DIV2 9'h040
`define CMC_BAUD_DIV3 9'h100
`define CMC_ZERO32 32'h00000000

`endif

/* design/cmc_mode_lut.v */
// lookup of six-bit clock mode into mode register image
`timescale 1ns/1ns
module cmc_mode_lut #(
   parameter [2047:0] MODE_TABLE = {64{32'h00000000}}
) (
   // mode in
   input wire [5:0] mode,
   // image out
   output wire [31:0] image
);
   // one 32-bit word per mode, entry 0 in low bits
   assign image = MODE_TABLE[{mode, 5'h00} +: 32];
endmodule

/* design/cmc_clk_div.v */
// programmable divider producing a one-cycle enable pulse
`timescale 1ns/1ns
module cmc_clk_div (
   // clock and reset
   input wire mclk,
   input wire rst,
   // divide ratio, at least two
   input wire [8:0] ratio,
   // enable out
   output reg pulse
);
   reg [8:0] count;

   always @(posedge mclk) begin
      if (rst) begin
         count <= 9'h000;
         pulse <= 1'b0;
      end else if (count >= ratio - 9'h001) begin
         // ratio compared every cycle, so a change acts on the running count at once
         count <= 9'h000;
         pulse <= 1'b1;
      end else begin
         count <= count + 9'h001;
         pulse <= 1'b0;
      end
   end
endmodule

/* design/cmc_top.v */
// clock mode configuration block with its registers on Avalon-MM
// Operation
// - six-bit mode joins three mode pins and three configuration-word bits
// - mode sampled only when internal power-on reset releases
// - serial controller clock always divided by four
// - baud divider bits 30-31 pick 4/16/64/256, power-on loads 01
// - baud divider change applied without disturbing any lock
// - control bit 27 disables clock output, power-on clears it
// - disabled clock output level is unspecified
// - mode register read-only, loaded at power-on, drives dividers and loops
// - mode bits 0-3 give core loop prediv 1 to 4
// - mode bits 8-11 give bus divide 2 to 6
// - mode bits 12-15 give comms divide 1 to 3
// - mode bits 16-19 give system loop prediv 1 to 6
// - mode bits 20-23 give system loop multiplier twice the code
// - mode bit 25 disables delay loop
// - mode register holds four-bit core divide, 0000 means one
// - core divide bits 28-31 map 0001..0101 to 2..6
`timescale 1ns/1ns
`include "cmc_consts.vh"
module cmc_top #(
   parameter [2047:0] MODE_TABLE = {64{32'h00000000}}
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // reset and strap pins
   input wire power_on_reset,
   input wire hard_reset_line,
   input wire [2:0] clock_mode_pins,
   input wire [2:0] clock_mode_high_bits,
   // avalon-mm slave
   input wire [16:0] address,
   input wire read,
   input wire write,
   input wire [3:0] byteenable,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   // decoded clock controls
   output reg [3:0] core_pll_prediv,
   output reg [3:0] core_pll_mult,
   output reg [3:0] bus_divide_factor,
   output reg [3:0] comms_divide_factor,
   output reg [3:0] system_pll_prediv,
   output reg [3:0] system_pll_multiplier,
   output reg delay_loop_disable,
   output reg [3:0] core_divide_factor,
   output reg mode_invalid,
   // clock enables and output
   output reg serial_clk_en,
   output reg baud_generator_clock,
   output reg clock_output,
   output reg clock_output_disable
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // power-on bit resets to its asserted level, so no false release follows rst
   reg [7:0] sync_a;
   reg [7:0] sync_b;
   reg por_prev;
   always @(posedge mclk) begin
      if (rst) begin
         sync_a <= `CMC_SYNC_RST;
         sync_b <= `CMC_SYNC_RST;
         por_prev <= 1'b1;
      end else begin
         sync_a <= {hard_reset_line, power_on_reset, clock_mode_high_bits, clock_mode_pins};
         sync_b <= sync_a;
         por_prev <= sync_b[`CMC_SYNC_POR];
      end
   end
   wire por_s = sync_b[`CMC_SYNC_POR];
   wire por_release = por_prev & ~por_s;

   // ----------------------------------------
   // mode latch and lookup
   // ----------------------------------------
   reg [5:0] mode;
   reg load_pend;
   reg [31:0] mode_reg;
   wire [31:0] image;
   // table reads the latched mode, so late strap motion cannot leak in
   cmc_mode_lut #(.MODE_TABLE(MODE_TABLE)) u_lut (
      .mode(mode),
      .image(image)
   );
   // hard reset deliberately not looked at here
   always @(posedge mclk) begin
      if (rst) begin
         mode <= 6'h00;
         load_pend <= 1'b0;
         mode_reg <= `CMC_ZERO32;
      end else begin
         load_pend <= por_release;
         if (por_release) begin
            // configuration-word bits above the pin bits
            mode <= {sync_b[5:3], sync_b[2:0]};
         end
         // image loaded one cycle after the latch
         if (load_pend) begin
            // reserved bits read back as zero
            mode_reg <= image & ~`CMC_MODE_RSV;
         end
      end
   end

   // ----------------------------------------
   // field decode
   // ----------------------------------------
   function [3:0] fld;
      input [31:0] w;
      input integer lo;
      begin
         fld = w[lo +: 4];
      end
   endfunction

   function in_range;
      input [3:0] v;
      input [3:0] lo;
      input [3:0] hi;
      begin
         in_range = (v >= lo) && (v <= hi);
      end
   endfunction

   wire [3:0] f_cpdf = fld(mode_reg, `CMC_CPDF_LO);
   wire [3:0] f_bus_divide_factor = fld(mode_reg, `CMC_BUS_DIVIDE_FACTOR_LO);
   wire [3:0] f_comms_divide_factor = fld(mode_reg, `CMC_COMMS_DIVIDE_FACTOR_LO);
   wire [3:0] f_spdf = fld(mode_reg, `CMC_SPDF_LO);
   wire [3:0] f_smf = fld(mode_reg, `CMC_SMF_LO);
   wire [3:0] f_cdf = fld(mode_reg, `CMC_CORE_DIVIDE_FACTOR_LO);
   // unused codes are flagged; limit keeping stays with the board designer
   // one flag per four-bit field except the core loop multiplier
   reg [5:0] field_bad;
   always @* begin
      field_bad[0] = ~in_range(f_cpdf, 4'h0, 4'h3);
      field_bad[1] = ~in_range(f_bus_divide_factor, 4'h1, 4'h5);
      field_bad[2] = ~in_range(f_comms_divide_factor, 4'h0, 4'h2);
      field_bad[3] = ~in_range(f_spdf, 4'h0, 4'h5);
      field_bad[4] = ~in_range(f_smf, 4'h5, 4'hF);
      field_bad[5] = ~in_range(f_cdf, 4'h0, 4'h5);
   end

   // ----------------------------------------
   // decoded outputs
   // ----------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         core_pll_prediv <= 4'h0;
         core_pll_mult <= 4'h0;
         bus_divide_factor <= 4'h0;
         comms_divide_factor <= 4'h0;
         system_pll_prediv <= 4'h0;
         system_pll_multiplier <= 4'h0;
         delay_loop_disable <= 1'b0;
         core_divide_factor <= 4'h0;
         mode_invalid <= 1'b0;
      end else begin
         // factors given as divide value minus one except bus divide as full value, multiplier as full value/2
         core_pll_prediv <= f_cpdf;
         core_pll_mult <= fld(mode_reg, `CMC_CMF_LO);
         bus_divide_factor <= f_bus_divide_factor + 4'h1;
         comms_divide_factor <= f_comms_divide_factor;
         system_pll_prediv <= f_spdf;
         system_pll_multiplier <= f_smf;
         delay_loop_disable <= mode_reg[`CMC_DLL_BIT];
         core_divide_factor <= (f_cdf == 4'h0) ? 4'h0 : f_cdf;
         mode_invalid <= |field_bad;
      end
   end

   // ----------------------------------------
   // control register
   // ----------------------------------------
   function hit;
      input [16:0] a;
      input [16:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // reserved bits always read back as zero
   function [31:0] ctrl_word;
      input [1:0] sel;
      input dis;
      begin
         ctrl_word = `CMC_ZERO32;
         ctrl_word[`CMC_BAUD_HI:`CMC_BAUD_LO] = sel;
         ctrl_word[`CMC_CLOCK_OUTPUT_DISABLE_BIT] = dis;
      end
   endfunction

   reg [1:0] baud_sel;
   reg clk_dis;
   wire sel_ctrl = hit(address, `CMC_OFS_CTRL);
   wire sel_mode = hit(address, `CMC_OFS_MODE);

   always @(posedge mclk) begin
      if (rst || por_s) begin
         // power-on only; hard reset leaves these alone
         baud_sel <= `CMC_BAUD_RST;
         clk_dis <= `CMC_CLOCK_OUTPUT_DISABLE_RST;
      end else if (write && waitrequest == 1'b0 && sel_ctrl && byteenable[3]) begin
         // reserved bits dropped on write
         baud_sel <= writedata[`CMC_BAUD_HI:`CMC_BAUD_LO];
         clk_dis <= writedata[`CMC_CLOCK_OUTPUT_DISABLE_BIT];
      end
   end

   // ----------------------------------------
   // bus answer: one wait cycle then acknowledge
   // ----------------------------------------
   // request taken while waitrequest is high, answered the next cycle
   always @(posedge mclk) begin
      if (rst) begin
         waitrequest <= 1'b1;
      end else if ((read || write) && waitrequest) begin
         waitrequest <= 1'b0;
      end else begin
         // a held request falls back to wait
         waitrequest <= 1'b1;
      end
   end

   // writes to the mode register or unmapped addresses change nothing
   always @(posedge mclk) begin
      if (rst) begin
         readdata <= `CMC_ZERO32;
      end else if ((read || write) && waitrequest) begin
         if (read && sel_ctrl) begin
            readdata <= ctrl_word(baud_sel, clk_dis);
         end else if (read && sel_mode) begin
            readdata <= mode_reg;
         end else begin
            // writes and unmapped reads answer zero
            readdata <= `CMC_ZERO32;
         end
      end
   end

   // ----------------------------------------
   // clock enables
   // ----------------------------------------
   reg [8:0] baud_ratio;
   always @* begin
      case (baud_sel)
         2'h0: baud_ratio = `CMC_BAUD_DIV0;
         2'h1: baud_ratio = `CMC_BAUD_DIV1;
         2'h2: baud_ratio = `CMC_BAUD_DIV2;
         default: baud_ratio = `CMC_BAUD_DIV3;
      endcase
   end
   wire ser_p;
   wire baud_p;
   // serial rate fixed at four, never taken from a register
   cmc_clk_div u_ser (
      .mclk(mclk),
      .rst(rst),
      .ratio(`CMC_SER_DIV),
      .pulse(ser_p)
   );
   // new ratio compared every cycle, a count already past it wraps at once
   cmc_clk_div u_baud (
      .mclk(mclk),
      .rst(rst),
      .ratio(baud_ratio),
      .pulse(baud_p)
   );
   always @(posedge mclk) begin
      if (rst) begin
         serial_clk_en <= 1'b0;
         baud_generator_clock <= 1'b0;
         clock_output_disable <= 1'b0;
      end else begin
         serial_clk_en <= ser_p;
         baud_generator_clock <= baud_p;
         clock_output_disable <= clk_dis;
      end
   end

   // ----------------------------------------
   // clock output pin
   // ----------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         clock_output <= 1'b0;
      end else if (!clk_dis) begin
         clock_output <= ~clock_output;
      end else begin
         // disabled output holds last level, any level allowed
         clock_output <= clock_output;
      end
   end
endmodule

/* test/cmc_properties.sv */
// assertions on the ports of the clock mode configuration block
`timescale 1ns/1ns
module cmc_properties (
   // clock and reset
   input wire mclk,
   input wire rst,
   input wire power_on_reset,
   // bus
   input wire [16:0] address,
   input wire read,
   input wire write,
   input wire [31:0] readdata,
   input wire waitrequest,
   // clock controls
   input wire [3:0] core_pll_prediv,
   input wire [3:0] comms_divide_factor,
   input wire [3:0] system_pll_prediv,
   input wire [3:0] system_pll_multiplier,
   input wire [3:0] core_divide_factor,
   input wire delay_loop_disable,
   input wire serial_clk_en,
   input wire baud_generator_clock,
   input wire clock_output,
   input wire clock_output_disable
);
   reg [3:0] quiet;
   wire ans = !waitrequest && read;
   wire ctrl_ans = ans && address == 17'h10C80;
   wire [20:0] mode_f = {core_pll_prediv, comms_divide_factor, system_pll_prediv, system_pll_multiplier,
                         core_divide_factor, delay_loop_disable};
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // cycles since power-on reset went low
   always @(posedge mclk) begin
      if (rst || power_on_reset) quiet <= 4'h0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
   end
   AST_SER_GAP: assert property (serial_clk_en |=> !serial_clk_en [*3] ##1 serial_clk_en)
      else $error("serial enable spacing wrong");
   AST_BAUD_GAP: assert property (baud_generator_clock |=> !baud_generator_clock [*3])
      else $error("baud pulses too close");
   AST_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no answer after request");
   AST_ONE_BEAT: assert property (!waitrequest |=> waitrequest)
      else $error("answer longer than one cycle");
   AST_MODE_HOLD: assert property (quiet > 4'h9 |-> $stable(mode_f))
      else $error("mode changed outside power-on reset");
   AST_CTRL_RSV: assert property (ctrl_ans |-> (readdata & 32'h37FFFFFF) == 32'h0)
      else $error("reserved control bits read nonzero");
   AST_CTRL_DIS: assert property (ctrl_ans |-> readdata[27] == clock_output_disable)
      else $error("disable output differs from register");
   AST_UNMAPPED: assert property (ans && address != 17'h10C80 && address != 17'h10C88 |-> readdata == 32'h0)
      else $error("unmapped read nonzero");
   AST_CLKO_HOLD: assert property (clock_output_disable [*3] |-> $past(clock_output) == $past(clock_output, 2))
      else $error("clock output moved while disabled");
   AST_CLKO_RUN: assert property ((quiet > 4'h9 && !clock_output_disable) [*3]
      |-> $past(clock_output) != $past(clock_output, 2))
      else $error("clock output stalled while enabled");
endmodule

/* test/tb_top.sv */
// self-checking bench for the clock mode configuration block
`timescale 1ns/1ns
module tb_top;
   logic mclk, rst, power_on_reset, hard_reset_line, read, write;
   logic [2:0] clock_mode_pins, clock_mode_high_bits;
   logic [16:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, q;
   logic waitrequest, delay_loop_disable, mode_invalid, serial_clk_en, baud_generator_clock;
   logic clock_output, clock_output_disable;
   logic [3:0] core_pll_prediv, core_pll_mult, bus_divide_factor, comms_divide_factor;
   logic [3:0] system_pll_prediv, system_pll_multiplier, core_divide_factor;
   int err_count = 0, n_tests = 0, n, c;
   localparam logic [16:0] CTRL = 17'h10C80, MODE = 17'h10C88;
   localparam logic [31:0] IMG = 32'h32A52453;
   cmc_top #(.MODE_TABLE(2048'h32A52453 << 1344)) cmc_top_i (.*);
   task complete_run;
      $display("errors %0d of %0d checks", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one bus cycle, held until waitrequest is sampled low
   task bus(input logic w, input logic [16:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      address <= a; writedata <= d; write <= w; read <= !w;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      read <= 1'b0; write <= 1'b0;
      if (i == 50) begin err_count++; complete_run; end
   endtask
   task rd(input logic [16:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0); chk(q, e);
   endtask
   // cycles between two pulses of the chosen enable
   task gap(input logic b);
      int i;
      for (i = 0; i < 600 && (b ? baud_generator_clock : serial_clk_en) !== 1'b1; i++) @(posedge mclk);
      n = 0;
      for (i = 0; i < 600; i++) begin
         @(posedge mclk); n++;
         if ((b ? baud_generator_clock : serial_clk_en) === 1'b1) break;
      end
   endtask
   initial begin
      mclk = 0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      repeat (100000) @(posedge mclk);
      err_count++;
      complete_run;
   end
   initial begin
      rst = 1; power_on_reset = 1; hard_reset_line = 0; clock_mode_pins = 3'h2; clock_mode_high_bits = 3'h5;
      address = 0; read = 0; write = 0; byteenable = 4'hF; writedata = 0;
      repeat (10) @(posedge mclk);
      rst <= 0;
      repeat (3) @(posedge mclk);
      power_on_reset <= 0;
      repeat (10) @(posedge mclk);
      rd(MODE, IMG);
      chk({core_pll_prediv, comms_divide_factor, system_pll_prediv, system_pll_multiplier,
           core_divide_factor, delay_loop_disable, mode_invalid}, {4'h3, 4'h2, 4'h5, 4'hA, 4'h3, 2'h2});
      chk({bus_divide_factor, core_pll_mult}, {4'h5, 4'h5});
      rd(CTRL, 32'h40000000);
      bus(1'b1, MODE, 32'hFFFFFFFF);
      rd(MODE, IMG);
      rd(17'h00004, 32'h0);
      gap(1'b0); chk(n, 4);
      for (c = 0; c < 4; c++) begin
         bus(1'b1, CTRL, c << 30);
         gap(1'b1); gap(1'b1); chk(n, 4 << (2 * c));
      end
      bus(1'b1, CTRL, 32'hC8000000);
      repeat (6) @(posedge mclk);
      chk(clock_output_disable, 1);
      hard_reset_line <= 1; clock_mode_pins <= 3'h0; clock_mode_high_bits <= 3'h0;
      repeat (10) @(posedge mclk);
      hard_reset_line <= 0;
      repeat (8) @(posedge mclk);
      rd(CTRL, 32'hC8000000);
      rd(MODE, IMG);
      power_on_reset <= 1;
      repeat (6) @(posedge mclk);
      power_on_reset <= 0;
      repeat (10) @(posedge mclk);
      rd(MODE, 32'h0);
      rd(CTRL, 32'h40000000);
      chk(mode_invalid, 1);
      complete_run;
   end
endmodule
bind cmc_top cmc_properties cmc_properties_i (.mclk, .rst, .power_on_reset, .address, .read, .write, .readdata,
   .waitrequest, .core_pll_prediv, .comms_divide_factor, .system_pll_prediv, .system_pll_multiplier,
   .core_divide_factor, .delay_loop_disable, .serial_clk_en, .baud_generator_clock, .clock_output,
   .clock_output_disable);
